//--- tefl_edge_detect.sv
// tefl_edge_detect: rising and falling edge pulses of a level input
// assumes: input synchronous to clock
`timescale 1ns/1ps
module tefl_edge_detect (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic level,
  output logic      rise,
  output logic      fall
);

  typedef struct packed {
    logic last_q;
  } tefl_edge_state_type;

  tefl_edge_state_type state_q;
  tefl_edge_state_type state_d;

  always_comb begin
    state_d        = state_q;
    state_d.last_q = level;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign rise = level && !state_q.last_q;
  assign fall = !level && state_q.last_q;

endmodule : tefl_edge_detect

//--- tefl_event_flags.sv
// tefl_event_flags: interrupt status flags of an advanced control timer
// assumes: counter core supplies one-cycle event pulses and the compare match level,
// software uses the plain register port with read data one cycle after the strobe
`timescale 1ns/1ps
module tefl_event_flags (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [15:0] reg_rdata,
  output logic             irq,
  input  wire logic        repetition_wrap,
  input  wire logic        software_reinit,
  input  wire logic        trigger_reinit,
  input  wire logic        trigger_input,
  input  wire logic        trigger_edge_valid,
  input  wire logic        commutation_event,
  input  wire logic        brake_input,
  input  wire logic        ch1_compare_match,
  input  wire logic        ch1_capture,
  input  wire logic [15:0] counter_value,
  input  wire logic        ch2_event,
  input  wire logic        ch3_event,
  output logic             update_event,
  output logic             capture_read
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [5:0]  control_q;
    logic [7:0]  mask_q;
    logic [7:0]  status_q;
    logic [15:0] capture_q;
    logic [15:0] rdata_q;
    logic        irq_q;
    logic        update_q;
    logic        cap_read_q;
    logic        brake_last_q;
  } tefl_state_type;

  tefl_state_type state_q;
  tefl_state_type state_d;

  logic [9:0]  flags;
  logic [9:0]  set_vec;
  logic [9:0]  clr_vec;
  logic [7:0]  ev_vec;
  logic        flag_write;
  logic        trig_rise;
  logic        trig_fall;
  logic        trig_event;
  logic        upd_gen;
  logic        upd_ev;
  logic        brake_active;
  logic        brake_event;
  logic        ch1_input;
  logic        cap_reg_read;

  // ----------------------------------------------------------------
  // event decode
  // ----------------------------------------------------------------
  tefl_edge_detect u_trig_edge (
    .clock (clock),
    .rst   (rst),
    .level (trigger_input),
    .rise  (trig_rise),
    .fall  (trig_fall)
  );

  assign flag_write   = reg_write && (reg_addr == tefl_pkg::ADDR_FLAGS);
  assign ch1_input    = state_q.control_q[tefl_pkg::CTL_CH1_INPUT];
  assign cap_reg_read = reg_read && (reg_addr == tefl_pkg::ADDR_CAPTURE);
  assign upd_gen      = reg_write && (reg_addr == tefl_pkg::ADDR_SWGEN)
                        && reg_wdata[tefl_pkg::GEN_UPDATE];

  // gated mode counts both edges, otherwise the core qualifies the edge
  assign trig_event = state_q.control_q[tefl_pkg::CTL_GATED_MODE] ?
                      (trig_rise || trig_fall) : trigger_edge_valid;

  // brake level is compared to the configured polarity, flag set on entry
  assign brake_active = brake_input == state_q.control_q[tefl_pkg::CTL_BRAKE_POLARITY];
  assign brake_event  = brake_active && !state_q.brake_last_q;

  always_comb begin
    upd_ev = 1'b0;
    if (!state_q.control_q[tefl_pkg::CTL_UPDATE_DISABLE]) begin
      if (repetition_wrap) begin
        upd_ev = 1'b1;
      end
      if (!state_q.control_q[tefl_pkg::CTL_UPDATE_SOURCE]) begin
        if (upd_gen || software_reinit) begin
          upd_ev = 1'b1;
        end
        if (trigger_reinit) begin
          upd_ev = 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // flag set and clear vectors
  // ----------------------------------------------------------------
  always_comb begin
    set_vec = '0;
    clr_vec = '0;
    set_vec[tefl_pkg::BIT_UPDATE]      = upd_ev;
    set_vec[tefl_pkg::BIT_CH1]         = ch1_input ? ch1_capture
      : (ch1_compare_match && !state_q.control_q[tefl_pkg::CTL_CENTRE_ALIGNED]);
    set_vec[tefl_pkg::BIT_CH2]         = ch2_event;
    set_vec[tefl_pkg::BIT_CH3]         = ch3_event;
    set_vec[tefl_pkg::BIT_COMMUTATION] = commutation_event;
    set_vec[tefl_pkg::BIT_TRIGGER]     = trig_event;
    set_vec[tefl_pkg::BIT_BRAKE]       = brake_event;
    set_vec[tefl_pkg::BIT_CH1_OVER]    = ch1_input && ch1_capture
                                         && flags[tefl_pkg::BIT_CH1];
    clr_vec[tefl_pkg::BIT_CH1]         = ch1_input && cap_reg_read;
  end

  genvar gi;
  generate
    for (gi = 0; gi < tefl_pkg::NUM_FLAGS; gi++) begin : g_flag
      if (tefl_pkg::FLAG_IMPLEMENTED[gi]) begin : g_impl
        // a written one is ignored, a written zero clears; bit 1 is also cleared by a capture read in input mode
        tefl_flag_bit u_bit (
          .clock       (clock),
          .rst         (rst),
          .set_event   (set_vec[gi]),
          .write_en    (flag_write),
          .write_bit   (reg_wdata[gi]),
          .clear_event (clr_vec[gi]),
          .flag        (flags[gi])
        );
      end else begin : g_resv
        assign flags[gi] = 1'b0;
      end
    end
  endgenerate

  // interrupt events follow the low eight flag positions, bit 4 is unused
  assign ev_vec = set_vec[7:0] & tefl_pkg::FLAG_IMPLEMENTED[7:0];

  // ----------------------------------------------------------------
  // registers, interrupt and read path
  // ----------------------------------------------------------------
  always_comb begin
    state_d              = state_q;
    state_d.update_q     = upd_ev;
    state_d.cap_read_q   = cap_reg_read;
    state_d.brake_last_q = brake_active;
    if (ch1_input && ch1_capture) begin
      state_d.capture_q = counter_value;
    end
    if (reg_write && reg_addr == tefl_pkg::ADDR_CONTROL) begin
      state_d.control_q = reg_wdata[5:0];
    end
    if (reg_write && reg_addr == tefl_pkg::ADDR_MASK) begin
      state_d.mask_q = reg_wdata[7:0];
    end
    state_d.rdata_q = 16'h0000;
    if (reg_read) begin
      case (reg_addr)
        tefl_pkg::ADDR_FLAGS:   state_d.rdata_q = {6'h00, flags};
        tefl_pkg::ADDR_CONTROL: state_d.rdata_q = {10'h000, state_q.control_q};
        tefl_pkg::ADDR_MASK:    state_d.rdata_q = {8'h00, state_q.mask_q};
        tefl_pkg::ADDR_STATUS:  state_d.rdata_q = {8'h00, state_q.status_q};
        tefl_pkg::ADDR_CAPTURE: state_d.rdata_q = state_q.capture_q;
        default:                state_d.rdata_q = 16'h0000;
      endcase
    end
    // reading status clears it, a fresh event in the same cycle survives
    if (reg_read && reg_addr == tefl_pkg::ADDR_STATUS) begin
      state_d.status_q = 8'h00;
    end
    state_d.status_q = state_d.status_q | ev_vec;
    state_d.irq_q    = |(state_d.status_q & state_d.mask_q);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q           <= '0;
      state_q.control_q <= tefl_pkg::CONTROL_RESET;
      state_q.mask_q    <= tefl_pkg::MASK_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign reg_rdata    = state_q.rdata_q;
  assign irq          = state_q.irq_q;
  assign update_event = state_q.update_q;
  assign capture_read = state_q.cap_read_q;

endmodule : tefl_event_flags

//--- tefl_event_flags_checker.sv
// tefl_event_flags_checker: port assertions for the timer event flag block
// assumes: bound into tefl_event_flags; one clock, synchronous reset
`timescale 1ns/1ps
module tefl_event_flags_checker (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [15:0] reg_rdata,
  input wire logic        repetition_wrap,
  input wire logic        software_reinit,
  input wire logic        trigger_reinit,
  input wire logic        update_event,
  input wire logic        capture_read
);
  // ----
  // shadow of the update controls, seen only through register writes
  // ----
  logic [1:0] ctl_q;
  logic       gen_w;
  logic       cause_w;
  assign gen_w   = reg_write && reg_addr == tefl_pkg::ADDR_SWGEN && reg_wdata[0];
  assign cause_w = repetition_wrap || software_reinit || trigger_reinit || gen_w;
  always_ff @(posedge clock) begin
    if (rst) begin
      ctl_q <= 2'h0;
    end else if (reg_write && reg_addr == tefl_pkg::ADDR_CONTROL) begin
      ctl_q <= reg_wdata[1:0];
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence flags_rd;
    reg_read && reg_addr == tefl_pkg::ADDR_FLAGS;
  endsequence
  sequence wrap_live;
    repetition_wrap && !ctl_q[0];
  endsequence
  sequence upd_kept;
    !(reg_write && reg_addr == tefl_pkg::ADDR_FLAGS && !reg_wdata[0]);
  endsequence
  rsvd_zero_a: assert property (flags_rd |=> reg_rdata[15:10] == 6'h00
    && !reg_rdata[8] && !reg_rdata[4]) else $error("reserved flag bits not zero");
  upd_flag_a: assert property (wrap_live ##1 upd_kept ##1 flags_rd |=> reg_rdata[0])
    else $error("update flag missing after wrap");
  wrap_upd_a: assert property (wrap_live |=> update_event)
    else $error("wrap gave no update event");
  upd_off_a: assert property (ctl_q[0] |=> !update_event)
    else $error("update event while disabled");
  soft_upd_a: assert property ((software_reinit || gen_w) && ctl_q == 2'h0
    |=> update_event) else $error("software cause gave no update event");
  trig_upd_a: assert property (trigger_reinit && ctl_q == 2'h0 |=> update_event)
    else $error("trigger reinit gave no update event");
  upd_cause_a: assert property (update_event |-> $past(cause_w))
    else $error("update event without a cause");
  cap_read_a: assert property (reg_read && reg_addr == tefl_pkg::ADDR_CAPTURE
    |=> capture_read) else $error("capture read pulse missing");
  cap_only_a: assert property (capture_read |->
    $past(reg_read && reg_addr == tefl_pkg::ADDR_CAPTURE)) else $error("stray capture read");
endmodule : tefl_event_flags_checker

bind tefl_event_flags tefl_event_flags_checker u_checker (
  .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .repetition_wrap(repetition_wrap), .software_reinit(software_reinit),
  .trigger_reinit(trigger_reinit), .update_event(update_event), .capture_read(capture_read));

//--- tefl_event_flags_tb.sv
// tefl_event_flags_tb: self-checking bench for the timer event flag block
// assumes: bench drives every port itself; events packed in one pulse vector
`timescale 1ns/1ps
module tefl_event_flags_tb;
  logic        clock = 1'b0, rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
  // brake idles at its inactive level: the reset polarity makes low the active level
  logic        trigger_input = 1'b0, brake_input = 1'b1, irq, update_event, capture_read;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, counter_value = 16'h0000, reg_rdata;
  logic [8:0]  ev_q = 9'h000;
  int          miscompares = 0, total_checks = 0;
  always #20 clock = ~clock;
  tefl_event_flags DUT (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq),
    .repetition_wrap(ev_q[0]), .software_reinit(ev_q[1]), .trigger_reinit(ev_q[2]),
    .trigger_input(trigger_input), .trigger_edge_valid(ev_q[3]), .commutation_event(ev_q[4]),
    .brake_input(brake_input), .ch1_compare_match(ev_q[5]), .ch1_capture(ev_q[6]),
    .counter_value(counter_value), .ch2_event(ev_q[7]), .ch3_event(ev_q[8]),
    .update_event(update_event), .capture_read(capture_read));
  // ----
  // bus and compare helpers
  // ----
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_write <= 1'b0;
    #1;
  endtask : wr
  task automatic rc(input logic [3:0] a, input logic [15:0] exp, input string what);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata, exp, what);
  endtask : rc
  task automatic ev(input logic [8:0] m);
    @(posedge clock);
    ev_q <= m;
    @(posedge clock);
    ev_q <= 9'h000;
    #1;
  endtask : ev
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  // ----
  // scenarios
  // ----
  task automatic t_reset();
    rc(tefl_pkg::ADDR_FLAGS, 16'h0000, "flags");
    rc(tefl_pkg::ADDR_STATUS, 16'h0000, "status");
    rc(4'hF, 16'h0000, "unmapped");
  endtask : t_reset
  task automatic t_update();
    ev(9'h001);
    chk(16'(update_event), 16'h0001, "wrap upd");
    rc(tefl_pkg::ADDR_FLAGS, 16'h0001, "upd flag");
    wr(tefl_pkg::ADDR_FLAGS, 16'hFFFF);
    rc(tefl_pkg::ADDR_FLAGS, 16'h0001, "write one");
    wr(tefl_pkg::ADDR_FLAGS, 16'hFFFE);
    rc(tefl_pkg::ADDR_FLAGS, 16'h0000, "write zero");
    ev(9'h002);
    chk(16'(update_event), 16'h0001, "sw reinit");
    ev(9'h004);
    chk(16'(update_event), 16'h0001, "trig reinit");
    wr(tefl_pkg::ADDR_SWGEN, 16'h0001);
    chk(16'(update_event), 16'h0001, "gen");
    wr(tefl_pkg::ADDR_CONTROL, 16'h0002);
    ev(9'h006);
    chk(16'(update_event), 16'h0000, "source set");
    ev(9'h001);
    chk(16'(update_event), 16'h0001, "wrap source");
    wr(tefl_pkg::ADDR_CONTROL, 16'h0001);
    ev(9'h001);
    chk(16'(update_event), 16'h0000, "disabled");
    wr(tefl_pkg::ADDR_CONTROL, 16'h0000);
    wr(tefl_pkg::ADDR_FLAGS, 16'h0000);
  endtask : t_update
  task automatic t_events();
    ev(9'h198);
    rc(tefl_pkg::ADDR_FLAGS, 16'h006C, "events");
    // one short visit to the active-low level is one entry
    @(posedge clock);
    brake_input <= 1'b0;
    @(posedge clock);
    brake_input <= 1'b1;
    rc(tefl_pkg::ADDR_FLAGS, 16'h00EC, "brake");
    wr(tefl_pkg::ADDR_FLAGS, 16'h0000);
    wr(tefl_pkg::ADDR_CONTROL, 16'h0010);
    trigger_input <= 1'b1;
    rc(tefl_pkg::ADDR_FLAGS, 16'h0040, "gated edge");
    wr(tefl_pkg::ADDR_FLAGS, 16'h0000);
    wr(tefl_pkg::ADDR_CONTROL, 16'h0000);
    trigger_input <= 1'b0;
    rc(tefl_pkg::ADDR_FLAGS, 16'h0000, "raw edge");
  endtask : t_events
  task automatic t_ch1();
    ev(9'h020);
    rc(tefl_pkg::ADDR_FLAGS, 16'h0002, "match");
    wr(tefl_pkg::ADDR_FLAGS, 16'h0000);
    wr(tefl_pkg::ADDR_CONTROL, 16'h0008);
    ev(9'h020);
    rc(tefl_pkg::ADDR_FLAGS, 16'h0000, "centre");
    wr(tefl_pkg::ADDR_CONTROL, 16'h0004);
    ev(9'h040);
    rc(tefl_pkg::ADDR_FLAGS, 16'h0002, "capture");
    counter_value <= 16'h5A3C;
    ev(9'h040);
    rc(tefl_pkg::ADDR_FLAGS, 16'h0202, "overcap");
    rc(tefl_pkg::ADDR_CAPTURE, 16'h5A3C, "cap data");
    chk(16'(capture_read), 16'h0001, "cap read");
    rc(tefl_pkg::ADDR_FLAGS, 16'h0200, "read clear");
    wr(tefl_pkg::ADDR_FLAGS, 16'hFDFF);
    rc(tefl_pkg::ADDR_FLAGS, 16'h0000, "over clear");
    wr(tefl_pkg::ADDR_CONTROL, 16'h0000);
  endtask : t_ch1
  task automatic t_irq();
    // every event of the low eight flag positions so far left its sticky status bit; this read also empties it
    rc(tefl_pkg::ADDR_STATUS, 16'h00EF, "status all");
    wr(tefl_pkg::ADDR_MASK, 16'h0001);
    ev(9'h001);
    @(posedge clock);
    #1;
    chk(16'(irq), 16'h0001, "irq");
    rc(tefl_pkg::ADDR_STATUS, 16'h0001, "status");
    @(posedge clock);
    #1;
    chk(16'(irq), 16'h0000, "irq clear");
    wr(tefl_pkg::ADDR_MASK, 16'h0000);
    ev(9'h001);
    @(posedge clock);
    #1;
    chk(16'(irq), 16'h0000, "masked");
  endtask : t_irq
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_update();
    t_events();
    t_ch1();
    t_irq();
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    stop_test();
  end
endmodule : tefl_event_flags_tb

//--- tefl_flag_bit.sv
// tefl_flag_bit: one sticky flag, set by hardware, cleared by writing zero or by a clear pulse
// assumes: single clock, synchronous active-high reset
`timescale 1ns/1ps
module tefl_flag_bit (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic set_event,
  input  wire logic write_en,
  input  wire logic write_bit,
  input  wire logic clear_event,
  output logic      flag
);

  typedef struct packed {
    logic flag_q;
  } tefl_bit_state_type;

  tefl_bit_state_type state_q;
  tefl_bit_state_type state_d;

  always_comb begin
    state_d = state_q;
    if ((write_en && !write_bit) || clear_event) begin
      state_d.flag_q = 1'b0;
    end
    // a set arriving with the clear wins so no event is lost
    if (set_event) begin
      state_d.flag_q = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign flag = state_q.flag_q;

endmodule : tefl_flag_bit

//--- tefl_pkg.sv
// tefl_pkg: register offsets, field positions and reset values of the timer event flag block
// assumes: nothing; shared by the flag block, its checker and its bench
package tefl_pkg;

  // ----------------------------------------------------------------
  // register map (word offsets on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [3:0]  ADDR_FLAGS   = 4'h0;
  localparam logic [3:0]  ADDR_CONTROL = 4'h1;
  localparam logic [3:0]  ADDR_MASK    = 4'h2;
  localparam logic [3:0]  ADDR_STATUS  = 4'h3;
  localparam logic [3:0]  ADDR_CAPTURE = 4'h4;
  localparam logic [3:0]  ADDR_SWGEN   = 4'h5;

  // ----------------------------------------------------------------
  // flag register field positions
  // ----------------------------------------------------------------
  localparam int BIT_UPDATE      = 0;
  localparam int BIT_CH1         = 1;
  localparam int BIT_CH2         = 2;
  localparam int BIT_CH3         = 3;
  localparam int BIT_COMMUTATION = 5;
  localparam int BIT_TRIGGER     = 6;
  localparam int BIT_BRAKE       = 7;
  localparam int BIT_CH1_OVER    = 9;
  localparam int NUM_FLAGS       = 10;
  localparam logic [9:0] FLAG_IMPLEMENTED = 10'h2EF;
  localparam logic [9:0] FLAG_RESET       = 10'h000;

  // ----------------------------------------------------------------
  // control register field positions
  // ----------------------------------------------------------------
  localparam int CTL_UPDATE_DISABLE = 0;
  localparam int CTL_UPDATE_SOURCE  = 1;
  localparam int CTL_CH1_INPUT      = 2;
  localparam int CTL_CENTRE_ALIGNED = 3;
  localparam int CTL_GATED_MODE     = 4;
  localparam int CTL_BRAKE_POLARITY = 5;
  localparam logic [5:0] CONTROL_RESET = 6'h00;

  // software generation register: bit 0 is update_generate
  localparam int GEN_UPDATE = 0;

  // interrupt status/mask events
  localparam int NUM_EVENTS  = 8;
  localparam logic [7:0] MASK_RESET = 8'h00;

endpackage : tefl_pkg
